// file: include/pbs_pkg.sv
// Notes on behaviour
// - a hybrid burst first walks the aligned group holding the start word, each word once.
// - after the hybrid wrap, words advance one at a time until chip select goes high.
// - when the hybrid wrap is done the next word is the first word of the next group.
// - hybrid enable bit 2 at 0 makes every wrapped transaction follow the hybrid order.
// - hybrid enable bit 2 at 1, its reset value, keeps wrapped transactions in the group.
// - a wrapped or hybrid burst starts at the commanded word and wraps only at group end.
// - command bit 45 at 1 forces a linear burst, at 0 the configured wrap behaviour.
// - burst length field selects a group of 16, 32, 64 or 128 bytes.
// - legacy wrap returns to the group start after its last word and keeps circling.
package pbs_pkg;
    localparam int ADDR_W   = 22;   // word address bits of the array
    localparam int MASK_W   = 6;    // largest group is 64 words
    // command-address word fields
    localparam int CA_W       = 48;
    localparam int CA_LINEAR  = 45;
    localparam int CA_UPPER_LO = 16;
    localparam int CA_UPPER_HI = 34;
    localparam int CA_LOWER_HI = 2;
    // configuration register zero fields
    localparam int CFG_W      = 16;
    localparam int CFG_LEGACY = 2;
    localparam int CFG_BL_HI  = 1;
    localparam int CFG_BL_LO  = 0;
    // burst length codes
    localparam logic [1:0] BL_128 = 2'h0;
    localparam logic [1:0] BL_64  = 2'h1;
    localparam logic [1:0] BL_16  = 2'h2;
    localparam logic [1:0] BL_32  = 2'h3;
    // word masks: group bytes / 2 words, minus one
    localparam logic [MASK_W-1:0] MASK_128 = 6'h3f;
    localparam logic [MASK_W-1:0] MASK_64  = 6'h1f;
    localparam logic [MASK_W-1:0] MASK_32  = 6'h0f;
    localparam logic [MASK_W-1:0] MASK_16  = 6'h07;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 22'h000000;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 22'h000001;
    localparam logic [MASK_W-1:0] CNT_ZERO  = 6'h00;
    localparam logic [MASK_W-1:0] CNT_ONE   = 6'h01;

    typedef enum logic [1:0] {ST_IDLE, ST_WRAP, ST_LIN} pbs_state_t;

    // decoded burst setup taken at start
    typedef struct packed {
        logic              linear;
        logic              hybrid;
        logic [MASK_W-1:0] mask;
        logic [ADDR_W-1:0] addr;
    } pbs_burst_t;
endpackage

// file: design/pbs_sequencer.sv
`timescale 1ns/100ps
module pbs_sequencer
(
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    input  wire logic                       bus_ck,
    input  wire logic                       bus_cs_n,
    input  wire logic                       start,
    input  wire logic [pbs_pkg::CA_W-1:0]   command_address_word,
    input  wire logic [pbs_pkg::CFG_W-1:0]  config_reg_zero,
    input  wire logic                       out_ready,
    output logic                            out_valid,
    output logic [pbs_pkg::ADDR_W-1:0]      out_addr,
    output logic                            busy,
    output logic                            overrun
);
    // pin synchronisers; first stages feed only the second stages
    logic ck_m_ff, ck_s_ff, ck_d_ff, cs_m_ff, cs_s_ff;
    logic ck_edge;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ck_m_ff <= 1'b0;
            ck_s_ff <= 1'b0;
            ck_d_ff <= 1'b0;
            cs_m_ff <= 1'b1;
            cs_s_ff <= 1'b1;
        end
        else
        begin
            ck_m_ff <= bus_ck;
            ck_s_ff <= ck_m_ff;
            ck_d_ff <= ck_s_ff;
            cs_m_ff <= bus_cs_n;
            cs_s_ff <= cs_m_ff;
        end
    end

    // one word per bus clock period, both ddr bytes make up one word
    assign ck_edge = ck_s_ff & ~ck_d_ff;

    // setup decode from the command word and config register
    pbs_pkg::pbs_burst_t setup;
    always_comb
    begin
        setup.linear = command_address_word[pbs_pkg::CA_LINEAR];
        setup.hybrid = ~config_reg_zero[pbs_pkg::CFG_LEGACY];
        setup.addr   = {command_address_word[pbs_pkg::CA_UPPER_HI:pbs_pkg::CA_UPPER_LO],
                        command_address_word[pbs_pkg::CA_LOWER_HI:0]};
        case (config_reg_zero[pbs_pkg::CFG_BL_HI:pbs_pkg::CFG_BL_LO])
            pbs_pkg::BL_128: setup.mask = pbs_pkg::MASK_128;
            pbs_pkg::BL_64:  setup.mask = pbs_pkg::MASK_64;
            pbs_pkg::BL_16:  setup.mask = pbs_pkg::MASK_16;
            pbs_pkg::BL_32:  setup.mask = pbs_pkg::MASK_32;
            default:         setup.mask = pbs_pkg::MASK_32;
        endcase
    end

    // sequencer state
    pbs_pkg::pbs_state_t       state_ff, nxt_state;
    logic [pbs_pkg::ADDR_W-1:0] addr_ff, nxt_addr, base_ff, nxt_base;
    logic [pbs_pkg::MASK_W-1:0] mask_ff, nxt_mask, cnt_ff, nxt_cnt;
    logic                       hybrid_ff, nxt_hybrid, pend_ff, nxt_pend;
    logic                       overrun_ff, nxt_overrun, busy_ff, nxt_busy;
    logic                       push, in_ready;
    logic [pbs_pkg::ADDR_W-1:0] wmask, wrap_next;

    // wrap step touches only the low group-index bits
    assign wmask     = {{(pbs_pkg::ADDR_W-pbs_pkg::MASK_W){1'b0}}, mask_ff};
    assign wrap_next = (addr_ff & ~wmask) | ((addr_ff + pbs_pkg::ADDR_ONE) & wmask);
    assign push      = pend_ff & in_ready;

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_addr    = addr_ff;
        nxt_base    = base_ff;
        nxt_mask    = mask_ff;
        nxt_cnt     = cnt_ff;
        nxt_hybrid  = hybrid_ff;
        nxt_pend    = pend_ff;
        nxt_overrun = overrun_ff;
        nxt_busy    = busy_ff;
        case (state_ff)
            pbs_pkg::ST_IDLE:
            begin
                nxt_pend = 1'b0;
                if (start)
                begin
                    nxt_addr    = setup.addr;
                    nxt_mask    = setup.mask;
                    nxt_base    = setup.addr & ~{{(pbs_pkg::ADDR_W-pbs_pkg::MASK_W){1'b0}},
                                                 setup.mask};
                    nxt_hybrid  = setup.hybrid;
                    nxt_cnt     = pbs_pkg::CNT_ZERO;
                    nxt_overrun = 1'b0;
                    nxt_busy    = 1'b1;
                    nxt_state   = setup.linear ? pbs_pkg::ST_LIN : pbs_pkg::ST_WRAP;
                end
            end
            pbs_pkg::ST_WRAP, pbs_pkg::ST_LIN:
            begin
                if (cs_s_ff)
                begin
                    // only chip select going high ends the burst
                    nxt_state = pbs_pkg::ST_IDLE;
                    nxt_pend  = 1'b0;
                    nxt_busy  = 1'b0;
                end
                else
                begin
                    // a bus edge that finds a word still waiting is a lost slot
                    nxt_pend = (pend_ff & ~push) | ck_edge;
                    if (ck_edge & pend_ff & ~push)
                        nxt_overrun = 1'b1;
                    if (push)
                    begin
                        if (state_ff == pbs_pkg::ST_LIN)
                            nxt_addr = addr_ff + pbs_pkg::ADDR_ONE;
                        else if (hybrid_ff && cnt_ff == mask_ff)
                        begin
                            // group covered once: jump to the following group
                            nxt_addr  = base_ff + wmask + pbs_pkg::ADDR_ONE;
                            nxt_state = pbs_pkg::ST_LIN;
                        end
                        else
                        begin
                            nxt_addr = wrap_next;
                            nxt_cnt  = cnt_ff + pbs_pkg::CNT_ONE;
                        end
                    end
                end
            end
            default:
            begin
                nxt_state = pbs_pkg::ST_IDLE;
                nxt_pend  = 1'b0;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff   <= pbs_pkg::ST_IDLE;
            addr_ff    <= pbs_pkg::ADDR_ZERO;
            base_ff    <= pbs_pkg::ADDR_ZERO;
            mask_ff    <= pbs_pkg::MASK_32;
            cnt_ff     <= pbs_pkg::CNT_ZERO;
            hybrid_ff  <= 1'b0;
            pend_ff    <= 1'b0;
            overrun_ff <= 1'b0;
            busy_ff    <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            addr_ff    <= nxt_addr;
            base_ff    <= nxt_base;
            mask_ff    <= nxt_mask;
            cnt_ff     <= nxt_cnt;
            hybrid_ff  <= nxt_hybrid;
            pend_ff    <= nxt_pend;
            overrun_ff <= nxt_overrun;
            busy_ff    <= nxt_busy;
        end
    end

    // two-entry buffer: head drives the outputs, spare catches a stalled word
    logic [pbs_pkg::ADDR_W-1:0] head_ff, nxt_head, spare_ff, nxt_spare;
    logic                       hval_ff, nxt_hval, sval_ff, nxt_sval;
    logic                       pop;

    assign in_ready = ~sval_ff;
    assign pop      = hval_ff & out_ready;

    always_comb
    begin
        nxt_head  = head_ff;
        nxt_spare = spare_ff;
        nxt_hval  = hval_ff;
        nxt_sval  = sval_ff;
        if (pop)
        begin
            if (sval_ff)
            begin
                nxt_head = spare_ff;
                nxt_sval = push;
                if (push)
                    nxt_spare = addr_ff;
            end
            else
            begin
                nxt_hval = push;
                if (push)
                    nxt_head = addr_ff;
            end
        end
        else if (push)
        begin
            if (hval_ff)
            begin
                nxt_spare = addr_ff;
                nxt_sval  = 1'b1;
            end
            else
            begin
                nxt_head = addr_ff;
                nxt_hval = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            head_ff  <= pbs_pkg::ADDR_ZERO;
            spare_ff <= pbs_pkg::ADDR_ZERO;
            hval_ff  <= 1'b0;
            sval_ff  <= 1'b0;
        end
        else
        begin
            head_ff  <= nxt_head;
            spare_ff <= nxt_spare;
            hval_ff  <= nxt_hval;
            sval_ff  <= nxt_sval;
        end
    end

    // outputs straight from flip-flops
    assign out_valid = hval_ff;
    assign out_addr  = head_ff;
    assign busy      = busy_ff;
    assign overrun   = overrun_ff;
endmodule

// file: dv/pbs_sequencer_monitor.sv
`timescale 1ns/100ps
module pbs_sequencer_monitor
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        bus_ck,
    input wire logic        bus_cs_n,
    input wire logic        start,
    input wire logic [47:0] command_address_word,
    input wire logic [15:0] config_reg_zero,
    input wire logic        out_ready,
    input wire logic        out_valid,
    input wire logic [21:0] out_addr,
    input wire logic        busy,
    input wire logic        overrun
);
    logic        lin_ff;
    logic        leg_ff;
    logic        have_ff;
    logic [5:0]  msk_ff;
    logic [7:0]  cnt_ff;
    logic [21:0] first_ff;
    logic [21:0] last_ff;
    wire         take = out_valid && out_ready;
    wire [21:0]  mk   = {16'h0000, msk_ff};
    wire [21:0]  grp  = (last_ff & ~mk) | ((last_ff + 22'h000001) & mk);
    wire [21:0]  jmp  = (first_ff | mk) + 22'h000001;
    wire [7:0]   top  = {2'h0, msk_ff};
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // burst setup copied at start; index counts handed-off words, saturating
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {lin_ff, leg_ff, have_ff, msk_ff, cnt_ff, first_ff, last_ff} <= '0;
        end
        else if (start && !busy)
        begin
            lin_ff   <= command_address_word[45];
            leg_ff   <= config_reg_zero[2];
            msk_ff   <= config_reg_zero[1] ? (config_reg_zero[0] ? 6'h0f : 6'h07)
                                           : (config_reg_zero[0] ? 6'h1f : 6'h3f);
            first_ff <= {command_address_word[34:16], command_address_word[2:0]};
            have_ff  <= 1'b0;
            cnt_ff   <= 8'h00;
        end
        else if (take)
        begin
            last_ff <= out_addr;
            have_ff <= 1'b1;
            cnt_ff  <= (cnt_ff == 8'hff) ? cnt_ff : cnt_ff + 8'h01;
        end
    end
    hold_stall_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_addr))
        else $error("word changed while stalled");
    busy_start_a: assert property (start && !busy |=> busy && !overrun)
        else $error("start not taken");
    busy_end_a: assert property ((bus_cs_n && !start) [*5] |-> !busy)
        else $error("burst outlived chip select");
    first_word_a: assert property (out_valid && !have_ff |-> out_addr == first_ff)
        else $error("first word is not the commanded word");
    lin_step_a: assert property (take && have_ff && lin_ff |-> out_addr == last_ff + 22'h000001)
        else $error("linear step wrong");
    leg_step_a: assert property (take && have_ff && !lin_ff && leg_ff |-> out_addr == grp)
        else $error("legacy wrap step wrong");
    hyb_wrap_a: assert property (take && have_ff && !lin_ff && !leg_ff && cnt_ff <= top
        |-> out_addr == grp)
        else $error("hybrid wrap step wrong");
    hyb_jump_a: assert property (take && !lin_ff && !leg_ff && cnt_ff == top + 8'h01
        |-> out_addr == jmp)
        else $error("hybrid jump wrong");
    hyb_lin_a: assert property (take && !lin_ff && !leg_ff && cnt_ff > top + 8'h01
        |-> out_addr == last_ff + 22'h000001)
        else $error("hybrid linear step wrong");
endmodule
bind pbs_sequencer pbs_sequencer_monitor mon (.clock(clock), .sys_rst(sys_rst), .bus_ck(bus_ck),
    .bus_cs_n(bus_cs_n), .start(start), .command_address_word(command_address_word),
    .config_reg_zero(config_reg_zero), .out_ready(out_ready), .out_valid(out_valid),
    .out_addr(out_addr), .busy(busy), .overrun(overrun));

// file: dv/pbs_host_model.sv
`timescale 1ns/100ps
module pbs_host_model
(
    output logic bus_ck,
    output logic bus_cs_n
);
    // bus clock stands low between frames, as a real controller leaves it
    initial
    begin
        bus_ck   = 1'b0;
        bus_cs_n = 1'b1;
    end
    // non-blocking so a call on a system clock edge cannot race the synchroniser
    task automatic open_frame();
        bus_cs_n <= 1'b0;
    endtask
    // 13 ns offset keeps bus edges off the system clock edges
    task automatic run_words(input int n);
        #13;
        repeat (n)
        begin
            #80 bus_ck = 1'b1;
            #80 bus_ck = 1'b0;
        end
    endtask
    // only raising chip select ends the burst
    task automatic close_frame();
        bus_cs_n <= 1'b1;
    endtask
endmodule

// file: dv/tb_pbs_sequencer.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_pbs_sequencer;
    logic        clock;
    logic        sys_rst;
    logic        start;
    logic [47:0] ca;
    logic [15:0] cfg;
    logic        out_ready;
    logic        out_valid;
    logic [21:0] out_addr;
    logic        busy;
    logic        overrun;
    wire         bus_ck;
    wire         bus_cs_n;
    int          error_cnt = 0;
    int          compares = 0;
    logic [21:0] got_q [$];
    logic [5:0]  msk_tab [4] = '{6'h3f, 6'h1f, 6'h07, 6'h0f};
    logic [5:0]  low_tab [4] = '{6'h03, 6'h2e, 6'h0c, 6'h1e};
    pbs_host_model host (.bus_ck(bus_ck), .bus_cs_n(bus_cs_n));
    pbs_sequencer dut (.clock(clock), .sys_rst(sys_rst), .bus_ck(bus_ck), .bus_cs_n(bus_cs_n),
        .start(start), .command_address_word(ca), .config_reg_zero(cfg), .out_ready(out_ready),
        .out_valid(out_valid), .out_addr(out_addr), .busy(busy), .overrun(overrun));
    always #10 clock = ~clock;
    // collect every word the receiver accepts
    always @(posedge clock)
        if (out_valid === 1'b1 && out_ready === 1'b1)
            got_q.push_back(out_addr);
    // mode 0 linear, 1 legacy wrap, 2 hybrid
    function automatic logic [21:0] exp_addr(input logic [21:0] st, input logic [5:0] m,
                                             input int mode, input int i);
        logic [21:0] mk;
        mk = {16'h0000, m};
        if (mode == 0)
            return st + 22'(i);
        if (mode == 2 && i > int'(m))
            return (st | mk) + 22'(i - int'(m));
        return (st & ~mk) | ((st + 22'(i)) & mk);
    endfunction
    task automatic results();
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one framed burst; poke retries start mid-burst and stalls the receiver briefly
    task automatic burst(input logic [1:0] bl, input logic leg, input logic lin,
                         input logic [21:0] st, input int n, input int mode, input bit poke);
        int k;
        got_q.delete();
        host.open_frame();
        repeat (3) @(posedge clock);
        cfg   <= {13'h1f00, leg, bl};
        ca    <= {2'h0, lin, 10'h000, st[21:3], 13'h0000, st[2:0]};
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        fork
            host.run_words(n);
            if (poke)
            begin
                repeat (30) @(posedge clock);
                start     <= 1'b1;
                ca        <= 48'h000000000000;
                out_ready <= 1'b0;
                @(posedge clock);
                start <= 1'b0;
                repeat (9) @(posedge clock);
                out_ready <= 1'b1;
            end
        join
        host.close_frame();
        `CHK(busy, 1'b1)
        for (k = 0; k < 60 && (busy !== 1'b0 || out_valid !== 1'b0); k++)
            @(negedge clock);
        // a stuck busy or a stuck word both count as a mismatch before the report
        if (k == 60)
        begin
            `CHK({busy, out_valid}, 2'h0)
            results();
        end
        else
        begin
            `CHK(overrun, 1'b0)
            `CHK(got_q.size(), n)
            for (k = 0; k < n && k < got_q.size(); k++)
                `CHK(got_q[k], exp_addr(st, msk_tab[bl], mode, k))
        end
    endtask
    task automatic t_hybrid();
        for (int b = 0; b < 4; b++)
            burst(2'(b), 1'b0, 1'b0, {16'h2b5a, low_tab[b]}, int'(msk_tab[b]) + 13, 2, 0);
    endtask
    task automatic t_legacy();
        for (int b = 0; b < 4; b++)
            burst(2'(b), 1'b1, 1'b0, {16'h1c37, low_tab[b]}, 2 * int'(msk_tab[b]) + 5, 1, 0);
    endtask
    // receiver not ready until after the burst: the bus cannot stall, so words are lost and flagged
    task automatic t_overrun();
        @(posedge clock);
        out_ready <= 1'b0;
        burst(2'h2, 1'b1, 1'b0, 22'h000004, 0, 1, 0);
        host.open_frame();
        repeat (3) @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        host.run_words(6);
        host.close_frame();
        repeat (8) @(negedge clock);
        `CHK(overrun, 1'b1)
        @(posedge clock);
        out_ready <= 1'b1;
        repeat (8) @(negedge clock);
        // the two buffered words survive the stall and drain in order
        `CHK(got_q.size(), 2)
        if (got_q.size() == 2)
            `CHK(got_q[1], exp_addr(22'h000004, 6'h07, 1, 1))
    endtask
    // linear bit overrides hybrid 128 setup across a group end; start while busy is ignored
    task automatic t_linear();
        burst(2'h0, 1'b0, 1'b1, 22'h2b5a3d, 20, 0, 1);
    endtask
    initial
    begin
        clock     = 1'b0;
        sys_rst   = 1'b1;
        start     = 1'b0;
        ca        = 48'h000000000000;
        cfg       = 16'h1f07;
        out_ready = 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        t_hybrid();
        t_legacy();
        t_overrun();
        t_linear();
        results();
    end
endmodule
